// File: core/spcfg_top.sv
// serial port configuration block with three serial engines
module spcfg_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic arst_n,
   // filling side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // draining side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data,
   // fill level
   output logic [$clog2(DEPTH):0] count
);
   import spcfg_pkg::*;
   localparam int AW = $clog2(DEPTH);
   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad
      $error("fifo depth must be a power of two");
   end
   logic [WIDTH-1:0] mem [DEPTH]; // storage
   logic [AW-1:0] wr, rd, next_wr, next_rd; // pointers
   logic [AW:0] next_count; // fill
   logic push, pop; // moves
   logic next_in_ready, next_out_valid; // registered flags
   logic [WIDTH-1:0] next_out_data; // registered head word
   // pointer, fill and head update
   always_comb begin
      push = in_valid && in_ready;
      pop = out_valid && out_ready;
      next_wr = wr + AW'(push);
      next_rd = rd + AW'(pop);
      next_count = count + (AW+1)'(push) - (AW+1)'(pop);
      next_in_ready = next_count != (AW+1)'(DEPTH);
      next_out_valid = next_count != '0;
      // a word landing in the head slot bypasses storage
      next_out_data = (push && next_rd == wr) ? in_data : mem[next_rd];
   end
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         wr <= '0;
         rd <= '0;
         count <= '0;
         in_ready <= 1'b1;
         out_valid <= 1'b0;
         out_data <= '0;
      end else begin
         wr <= next_wr;
         rd <= next_rd;
         count <= next_count;
         in_ready <= next_in_ready;
         out_valid <= next_out_valid;
         out_data <= next_out_data;
      end
   end
   // storage write, no reset needed
   always_ff @(posedge core_clk) begin
      if (push) begin
         mem[wr] <= in_data;
      end
   end
endmodule // spcfg_fifo

module spcfg_port #(
   parameter int CLK_HZ = 200_000_000,
   parameter int DEPTH = 8
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic arst_n,
   // settings
   input wire spcfg_pkg::spcfg_line_type cfg,
   input wire logic use_illum,
   // pins
   input wire logic rx_pin,
   input wire logic illum_pin,
   input wire logic cts_n,
   output logic tx_pin,
   output logic rts_n,
   // transmit data
   input wire logic [7:0] tx_data,
   input wire logic tx_valid,
   output logic tx_ready,
   // receive data
   output logic [7:0] rx_data,
   output logic rx_valid,
   input wire logic rx_ready,
   // fifo level flags
   output logic rx_level,
   output logic tx_level
);
   import spcfg_pkg::*;
   localparam int CW = $clog2(DEPTH) + 1;
   if (CLK_HZ / SLOWEST_RATE >= 262144 || CLK_HZ / FASTEST_RATE < 4)
   begin : g_bad
      $error("clock rate cannot serve the rate table");
   end
   typedef enum {T_IDLE, T_START, T_DATA, T_PAR, T_STOP} spcfg_tx_type;
   typedef enum {R_IDLE, R_START, R_DATA, R_PAR, R_STOP} spcfg_rx_type;
   // cycles per bit, unknown codes fall back to the first rate
   function automatic logic [17:0] bit_period(input logic [3:0] sel);
      int r;
      r = (sel < 4'(NUM_RATES)) ? RATE_TABLE[sel] : RATE_TABLE[0];
      return 18'(CLK_HZ / r);
   endfunction
   // fill count for a threshold code
   function automatic logic [CW-1:0] level_of(input logic [2:0] sel);
      unique case (sel)
         3'h0: return CW'(DEPTH / 8);
         3'h1: return CW'(DEPTH / 4);
         3'h2: return CW'(DEPTH / 2);
         3'h3: return CW'(DEPTH * 3 / 4);
         default: return CW'(DEPTH * 7 / 8);
      endcase
   endfunction
   // parity bit over the active data bits
   function automatic logic parity_of(input logic [7:0] d,
      input logic [1:0] len, input logic [1:0] kind);
      return ^(d & (8'hFF >> (2'h3 - len))) ^ (kind == CHK_ODD);
   endfunction
   // three-stage input capture: rx, cts, illum
   logic [2:0] s1, s2, s3, filt, next_filt;
   always_comb begin
      next_filt = (s2 & s3) | (filt & (s2 ^ s3)); // agree then take
   end
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         s1 <= 3'h7;
         s2 <= 3'h7;
         s3 <= 3'h7;
         filt <= 3'h7;
      end else begin
         s1 <= {illum_pin, cts_n, rx_pin};
         s2 <= s1;
         s3 <= s2;
         filt <= next_filt;
      end
   end
   logic rx_bit, cts_ok; // conditioned inputs
   logic [17:0] per; // bit period
   logic [2:0] last; // last data bit index
   logic par_on; // parity enabled
   always_comb begin
      rx_bit = (use_illum ? filt[2] : filt[0]) ^ cfg.input_invert;
      cts_ok = !cfg.handshake_select || !filt[1];
      per = bit_period(cfg.baud_select);
      last = 3'h4 + 3'(cfg.word_length);
      par_on = cfg.check_kind == CHK_EVEN || cfg.check_kind == CHK_ODD;
   end
   // fifos on both data paths
   logic [7:0] tf_data;
   logic tf_valid, tf_pop, rf_push, rf_room;
   logic [CW-1:0] tf_cnt, rf_cnt;
   logic [7:0] rsh, next_rsh;
   spcfg_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_txf (
      .core_clk(core_clk), .arst_n(arst_n),
      .in_valid(tx_valid), .in_ready(tx_ready), .in_data(tx_data),
      .out_valid(tf_valid), .out_ready(tf_pop), .out_data(tf_data),
      .count(tf_cnt));
   spcfg_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_rxf (
      .core_clk(core_clk), .arst_n(arst_n),
      .in_valid(rf_push), .in_ready(rf_room), .in_data(rsh),
      .out_valid(rx_valid), .out_ready(rx_ready), .out_data(rx_data),
      .count(rf_cnt));
   // transmitter
   spcfg_tx_type ts, next_ts;
   logic [17:0] tc, next_tc;
   logic [2:0] tb, next_tb;
   logic [7:0] tsh, next_tsh;
   logic next_tx;
   always_comb begin
      next_ts = ts;
      next_tc = (tc != '0) ? tc - 18'h1 : tc;
      next_tb = tb;
      next_tsh = tsh;
      next_tx = tx_pin;
      tf_pop = 1'b0;
      unique case (ts)
         T_IDLE: begin
            next_tx = 1'b1;
            if (cfg.port_enable && tf_valid && cts_ok) begin
               tf_pop = 1'b1;
               next_tsh = tf_data;
               next_tx = 1'b0;
               next_tc = per - 18'h1;
               next_ts = T_START;
            end
         end
         T_START: if (tc == '0) begin
            next_ts = T_DATA;
            next_tb = '0;
            next_tx = tsh[0];
            next_tc = per - 18'h1;
         end
         T_DATA: if (tc == '0) begin
            next_tc = per - 18'h1;
            next_tb = tb + 3'h1;
            next_tx = tsh[next_tb];
            if (tb == last) begin
               next_tb = '0;
               next_tx = par_on ? parity_of(tsh, cfg.word_length,
                  cfg.check_kind) : 1'b1;
               next_ts = par_on ? T_PAR : T_STOP;
            end
         end
         T_PAR: if (tc == '0) begin
            next_tx = 1'b1;
            next_tc = per - 18'h1;
            next_ts = T_STOP;
         end
         T_STOP: if (tc == '0) begin
            next_tc = per - 18'h1;
            next_tb = tb + 3'h1;
            if (tb == 3'(cfg.stop_count)) begin
               next_ts = T_IDLE;
            end
         end
      endcase
   end
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         ts <= T_IDLE;
         tc <= '0;
         tb <= '0;
         tsh <= '0;
         tx_pin <= 1'b1;
      end else begin
         ts <= next_ts;
         tc <= next_tc;
         tb <= next_tb;
         tsh <= next_tsh;
         tx_pin <= next_tx;
      end
   end
   // receiver, bad characters are dropped
   spcfg_rx_type rs, next_rs;
   logic [17:0] rc, next_rc;
   logic [2:0] rb, next_rb;
   logic rbad, next_rbad;
   always_comb begin
      next_rs = rs;
      next_rc = (rc != '0) ? rc - 18'h1 : rc;
      next_rb = rb;
      next_rsh = rsh;
      next_rbad = rbad;
      rf_push = 1'b0;
      unique case (rs)
         R_IDLE: if (cfg.port_enable && !rx_bit) begin
            next_rc = (per >> 1) - 18'h1;
            next_rs = R_START;
         end
         R_START: if (rc == '0) begin
            next_rs = rx_bit ? R_IDLE : R_DATA; // false start back
            next_rc = per - 18'h1;
            next_rb = '0;
            next_rsh = '0;
            next_rbad = 1'b0;
         end
         R_DATA: if (rc == '0) begin
            next_rsh[rb] = rx_bit;
            next_rb = rb + 3'h1;
            next_rc = per - 18'h1;
            if (rb == last) begin
               next_rs = par_on ? R_PAR : R_STOP;
            end
         end
         R_PAR: if (rc == '0) begin
            next_rbad = rx_bit != parity_of(rsh, cfg.word_length,
               cfg.check_kind);
            next_rc = per - 18'h1;
            next_rs = R_STOP;
         end
         R_STOP: if (rc == '0) begin
            rf_push = rx_bit && !rbad && rf_room;
            next_rs = R_IDLE;
         end
      endcase
   end
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         rs <= R_IDLE;
         rc <= '0;
         rb <= '0;
         rsh <= '0;
         rbad <= 1'b0;
      end else begin
         rs <= next_rs;
         rc <= next_rc;
         rb <= next_rb;
         rsh <= next_rsh;
         rbad <= next_rbad;
      end
   end
   // handshake and level flags
   logic next_rts_n, next_rx_level, next_tx_level;
   always_comb begin
      next_rts_n = cfg.handshake_select &&
         rf_cnt > CW'(DEPTH - 2);
      next_rx_level = rf_cnt >= level_of(cfg.receive_threshold);
      next_tx_level = tf_cnt <= level_of(cfg.transmit_threshold);
   end
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         rts_n <= 1'b0;
         rx_level <= 1'b0;
         tx_level <= 1'b1;
      end else begin
         rts_n <= next_rts_n;
         rx_level <= next_rx_level;
         tx_level <= next_tx_level;
      end
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!arst_n);
   property p_off_idle;
      ts == T_IDLE && !cfg.port_enable |=> ts == T_IDLE;
   endproperty
   a_off_idle: assert property (p_off_idle) else $error("sent while off");
   property p_cts_hold;
      ts == T_IDLE && cfg.handshake_select && filt[1] |=> tx_pin;
   endproperty
   a_cts_hold: assert property (p_cts_hold) else $error("sent sans cts");
   property p_rts_full;
      cfg.handshake_select && $past(cfg.handshake_select) &&
         rf_cnt == CW'(DEPTH) |-> rts_n;
   endproperty
   a_rts_full: assert property (p_rts_full) else $error("rts while full");
   property p_stop_end;
      ts == T_STOP && tc == '0 && tb == 3'(cfg.stop_count) |=> ts == T_IDLE;
   endproperty
   a_stop_end: assert property (p_stop_end) else $error("stop count");
   property p_period;
      ts == T_IDLE && next_ts == T_START |=> tc == $past(per) - 18'h1 ##1
         tc == $past(per, 2) - 18'h2;
   endproperty
   a_period: assert property (p_period) else $error("bit period");
   property p_rx_level;
      1'b1 |=> rx_level == ($past(rf_cnt) >= $past(level_of(
         cfg.receive_threshold)));
   endproperty
   a_rx_level: assert property (p_rx_level) else $error("rx level");
   property p_tx_level;
      1'b1 |=> tx_level == ($past(tf_cnt) <= $past(level_of(
         cfg.transmit_threshold)));
   endproperty
   a_tx_level: assert property (p_tx_level) else $error("tx level");
   property p_word_end;
      ts == T_DATA && tc == '0 && tb == last && !par_on |=> ts == T_STOP;
   endproperty
   a_word_end: assert property (p_word_end) else $error("word length");
endmodule // spcfg_port

module spcfg_top #(
   parameter int CLK_HZ = 200_000_000,
   parameter int DEPTH = 8
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic arst_n,
   // command port
   input wire spcfg_pkg::spcfg_cmd_type cmd,
   input wire logic rsp_take,
   output logic rsp_valid,
   output logic [7:0] rsp_byte,
   // serial pins
   input wire logic [2:0] ser_rx_pin,
   input wire logic illum_status_pin,
   input wire logic [2:0] clear_to_send_n,
   output logic [2:0] ser_tx_pin,
   output logic [2:0] request_to_send_n,
   // user data per port
   input wire logic [2:0][7:0] tx_data,
   input wire logic [2:0] tx_valid,
   output logic [2:0] tx_ready,
   output logic [2:0][7:0] rx_data,
   output logic [2:0] rx_valid,
   input wire logic [2:0] rx_ready,
   // status
   output logic [2:0] rx_level_flag,
   output logic [2:0] tx_level_flag,
   output logic update_link_on
);
   import spcfg_pkg::*;
   spcfg_line_type line_cfg [3], next_line_cfg [3]; // per-port settings
   logic [1:0] psel, next_psel; // configured port
   logic [1:0] src_bits, next_src_bits; // sources, ports 1 and 2
   logic src_port, next_src_port; // last rerouted port
   logic next_upd; // auto-update link
   logic active, next_active, rd, next_rd; // transaction state
   logic [7:0] code, next_code; // sub-address
   logic [3:0] nb, next_nb, rlen, next_rlen; // byte counts
   logic [79:0] wbuf, next_wbuf, rbuf, next_rbuf; // payloads
   // bytes a write needs, zero when unknown
   function automatic logic [3:0] bytes_in(input logic [7:0] c);
      unique case (c)
         CMD_LINE: return LINE_IN;
         CMD_PSEL: return PSEL_IN;
         CMD_SRC: return SRC_IN;
         CMD_UPD: return UPD_IN;
         default: return 4'h0;
      endcase
   endfunction
   // left-aligned reply image and its length
   function automatic logic [83:0] reply(input logic [7:0] c);
      logic [79:0] img;
      spcfg_line_type l;
      img = '0;
      l = line_cfg[psel];
      unique case (c)
         CMD_LINE: begin
            img[POS_PE] = l.port_enable;
            img[POS_BR+:4] = l.baud_select;
            img[POS_DB+:2] = l.word_length;
            img[POS_SB] = l.stop_count;
            img[POS_PAR+:2] = l.check_kind;
            img[POS_FC] = l.handshake_select;
            img[POS_RXT+:3] = l.receive_threshold;
            img[POS_TXT+:3] = l.transmit_threshold;
            img[POS_INV] = l.input_invert;
            return {LINE_OUT, img};
         end
         CMD_PSEL: begin
            img[73:72] = psel;
            img[66:64] = {line_cfg[2].port_enable,
               line_cfg[1].port_enable, line_cfg[0].port_enable};
            return {PSEL_OUT, img};
         end
         CMD_SRC: begin
            img[72+POS_SRC] = src_bits[src_port];
            return {SRC_OUT, img};
         end
         default: return {4'h0, img};
      endcase
   endfunction
   // command decode and commit
   always_comb begin
      next_line_cfg = line_cfg;
      next_psel = psel;
      next_src_bits = src_bits;
      next_src_port = src_port;
      next_upd = update_link_on;
      next_active = active;
      next_rd = rd;
      next_code = code;
      next_nb = nb;
      next_wbuf = wbuf;
      next_rbuf = rbuf;
      next_rlen = rlen;
      if (rsp_take && rlen != '0) begin // shift out next byte
         next_rbuf = {rbuf[71:0], 8'h00};
         next_rlen = rlen - 4'h1;
      end
      if (cmd.start) begin // new transaction
         next_active = 1'b1;
         next_rd = cmd.read;
         next_nb = '0;
         next_wbuf = '0;
         next_rlen = '0;
      end else if (cmd.valid && active) begin
         if (nb == '0) begin // sub-address byte
            next_code = cmd.data;
            next_nb = 4'h1;
            if (rd) begin
               {next_rlen, next_rbuf} = reply(cmd.data);
            end
         end else if (nb <= bytes_in(code)) begin // extra bytes dropped
            next_wbuf = {wbuf[71:0], cmd.data};
            next_nb = nb + 4'h1;
         end
      end else if (cmd.stop && active) begin
         next_active = 1'b0;
         if (!rd && nb > bytes_in(code)) begin // short writes ignored
            unique case (code)
               CMD_LINE: begin
                  next_line_cfg[psel].port_enable = wbuf[POS_PE];
                  next_line_cfg[psel].baud_select = wbuf[POS_BR+:4];
                  next_line_cfg[psel].word_length = wbuf[POS_DB+:2];
                  next_line_cfg[psel].stop_count = wbuf[POS_SB];
                  next_line_cfg[psel].check_kind = wbuf[POS_PAR+:2];
                  next_line_cfg[psel].handshake_select = wbuf[POS_FC];
                  next_line_cfg[psel].receive_threshold = wbuf[POS_RXT+:3];
                  next_line_cfg[psel].transmit_threshold = wbuf[POS_TXT+:3];
                  next_line_cfg[psel].input_invert = wbuf[POS_INV];
               end
               CMD_PSEL: if (wbuf[1:0] != 2'h3) begin
                  next_psel = wbuf[1:0];
               end
               CMD_SRC: begin
                  next_src_port = wbuf[POS_SRC_PORT];
                  next_src_bits[wbuf[POS_SRC_PORT]] = wbuf[POS_SRC];
               end
               CMD_UPD: next_upd = wbuf[0];
               default: next_upd = update_link_on; // unknown: nothing
            endcase
         end
      end
   end
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         line_cfg <= '{default: LINE_RESET};
         psel <= '0;
         src_bits <= '0;
         src_port <= 1'b0;
         update_link_on <= 1'b0;
         active <= 1'b0;
         rd <= 1'b0;
         code <= '0;
         nb <= '0;
         wbuf <= '0;
         rbuf <= '0;
         rlen <= '0;
         rsp_valid <= 1'b0;
      end else begin
         line_cfg <= next_line_cfg;
         psel <= next_psel;
         src_bits <= next_src_bits;
         src_port <= next_src_port;
         update_link_on <= next_upd;
         active <= next_active;
         rd <= next_rd;
         code <= next_code;
         nb <= next_nb;
         wbuf <= next_wbuf;
         rbuf <= next_rbuf;
         rlen <= next_rlen;
         rsp_valid <= next_rlen != '0;
      end
   end
   assign rsp_byte = rbuf[79:72];
   // port 0 always reads its own pin
   logic [2:0] illum_sel;
   assign illum_sel = {src_bits, 1'b0};
   for (genvar p = 0; p < 3; p++) begin : g_port
      spcfg_port #(.CLK_HZ(CLK_HZ), .DEPTH(DEPTH)) u_port (
         .core_clk(core_clk), .arst_n(arst_n),
         .cfg(line_cfg[p]), .use_illum(illum_sel[p]),
         .rx_pin(ser_rx_pin[p]), .illum_pin(illum_status_pin),
         .cts_n(clear_to_send_n[p]), .tx_pin(ser_tx_pin[p]),
         .rts_n(request_to_send_n[p]),
         .tx_data(tx_data[p]), .tx_valid(tx_valid[p]),
         .tx_ready(tx_ready[p]), .rx_data(rx_data[p]),
         .rx_valid(rx_valid[p]), .rx_ready(rx_ready[p]),
         .rx_level(rx_level_flag[p]), .tx_level(tx_level_flag[p]));
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!arst_n);
   property p_other_ports;
      cmd.stop && active && !rd && code == CMD_LINE && nb > LINE_IN &&
         psel == 2'h0 |=> $stable(line_cfg[1]) && $stable(line_cfg[2]);
   endproperty
   a_other_ports: assert property (p_other_ports) else $error("port mix");
   property p_short_line;
      cmd.stop && active && !rd && code == CMD_LINE && nb <= LINE_IN
         |=> line_cfg[psel] == $past(line_cfg[psel]);
   endproperty
   a_short_line: assert property (p_short_line) else $error("short write");
endmodule // spcfg_top

// File: core/spcfg_pkg.sv
// constants and types of the serial port configuration block
// Notes on behaviour
// - port_enable bit turns the port on
// - baud_select picks one of eleven rates
// - word_length gives five to eight data bits
// - stop_count gives one or two stops
// - check_kind gives none, even or odd
// - handshake_select turns hardware handshaking on
// - send only while clear_to_send_n is low
// - request data only while receive FIFO has room
// - receive level flag at chosen fill fraction
// - transmit level flag at chosen fill fraction
// - input_invert flips the receive input
// - port-number field selects the configured port
// - source rerouting only on ports one, two
// - source bit picks own pin or illum_status_pin
// - update_link_on connects the auto-update link
// - line setup writes touch only selected port
package spcfg_pkg;
   // command codes
   localparam logic [7:0] CMD_LINE = 8'hE3;
   localparam logic [7:0] CMD_PSEL = 8'hE4;
   localparam logic [7:0] CMD_SRC = 8'hE5;
   localparam logic [7:0] CMD_UPD = 8'hE6;
   // bytes in and out per command
   localparam logic [3:0] LINE_IN = 4'hA;
   localparam logic [3:0] LINE_OUT = 4'hA;
   localparam logic [3:0] PSEL_IN = 4'h1;
   localparam logic [3:0] PSEL_OUT = 4'h2;
   localparam logic [3:0] SRC_IN = 4'h2;
   localparam logic [3:0] SRC_OUT = 4'h1;
   localparam logic [3:0] UPD_IN = 4'h1;
   // field positions in the line setup image and the source image
   localparam int POS_PE = 64;
   localparam int POS_BR = 56;
   localparam int POS_DB = 47;
   localparam int POS_SB = 40;
   localparam int POS_PAR = 32;
   localparam int POS_FC = 24;
   localparam int POS_RXT = 16;
   localparam int POS_TXT = 8;
   localparam int POS_INV = 0;
   localparam int POS_SRC_PORT = 8;
   localparam int POS_SRC = 0;
   // rates in listed order
   localparam int NUM_RATES = 11;
   localparam int RATE_TABLE [NUM_RATES] = '{2400, 4800, 9600, 14400,
      19200, 38400, 57600, 115200, 1200, 923080, 230400};
   localparam int SLOWEST_RATE = 1200;
   localparam int FASTEST_RATE = 923080;
   // parity kinds
   localparam logic [1:0] CHK_EVEN = 2'h1;
   localparam logic [1:0] CHK_ODD = 2'h2;
   // one port's settings
   typedef struct packed {
      logic port_enable;
      logic [3:0] baud_select;
      logic [1:0] word_length;
      logic stop_count;
      logic [1:0] check_kind;
      logic handshake_select;
      logic [2:0] receive_threshold;
      logic [2:0] transmit_threshold;
      logic input_invert;
   } spcfg_line_type;
   localparam spcfg_line_type LINE_RESET = '0;
   // one command-port strobe set
   typedef struct packed {
      logic start;
      logic stop;
      logic read;
      logic valid;
      logic [7:0] data;
   } spcfg_cmd_type;
endpackage

// File: tb/spcfg_peer.sv
// remote serial peer: sends framed bytes, collects framed bytes
module spcfg_peer #(
   parameter int BIT_NS = 50
) (
   // line from the device, line to it, handshake
   input wire logic line_in,
   output logic line_out,
   output logic cts_n
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] got[$]; // bytes seen on the line
   initial begin
      line_out = 1'b1; // idle high between frames
      cts_n = 1'b0; // able to accept unless held
   end
   // hold off or release the device's transmitter
   task automatic hold(input logic h);
      cts_n = h;
   endtask
   // start low, eight bits lsb first, stop high
   task automatic send(input logic [7:0] b);
      for (int i = -1; i < 9; i++) begin
         line_out = (i < 0) ? 1'b0 : (i > 7) ? 1'b1 : b[i];
         #(BIT_NS);
      end
   endtask
   // sample mid-bit after each start edge
   always begin
      logic [7:0] b;
      @(negedge line_in);
      #(BIT_NS * 3 / 2);
      for (int i = 0; i < 8; i++) begin
         b[i] = line_in;
         #(BIT_NS);
      end
      if (line_in) got.push_back(b);
   end
endmodule // spcfg_peer

// File: tb/tb_spcfg_top.sv
// self-checking bench for the serial port configuration block
module tb_spcfg_top;
   timeunit 1ns;
   timeprecision 1ps;
   import spcfg_pkg::*;
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin \
   num_errors++; $display("Error %s exp %0h got %0h", n, e, s); end end
   logic core_clk = 1'b0;
   logic arst_n = 1'b0;
   spcfg_cmd_type cmd = '0;
   logic rsp_take = 1'b0;
   logic rsp_valid, update_link_on, peer_rx, peer_cts;
   logic [7:0] rsp_byte, b;
   logic [2:0][7:0] tx_data = '0;
   logic [2:0][7:0] rx_data;
   logic [2:0] tx_valid = '0;
   logic [2:0] rx_ready = '0;
   logic [2:0] tx_ready, rx_valid, ser_tx_pin, request_to_send_n;
   logic [2:0] rx_level_flag, tx_level_flag;
   wire logic [2:0] ser_rx_pin = {2'b11, peer_rx};
   wire logic [2:0] clear_to_send_n = {2'b11, peer_cts};
   wire logic illum_status_pin = peer_rx; // same frames on the alt source
   int num_errors = 0;
   int comparisons = 0;
   logic [79:0] v;
   logic [79:0] mdl [3] = '{default: '0}; // model: line image per port
   int sel = 0; // model: selected port
   // 230400 baud gives ten clocks a bit
   spcfg_top #(.CLK_HZ(2304000), .DEPTH(8)) uut (.core_clk, .arst_n,
      .cmd, .rsp_take, .rsp_valid, .rsp_byte, .ser_rx_pin,
      .illum_status_pin, .clear_to_send_n, .ser_tx_pin,
      .request_to_send_n, .tx_data, .tx_valid, .tx_ready, .rx_data,
      .rx_valid, .rx_ready, .rx_level_flag, .tx_level_flag,
      .update_link_on);
   spcfg_peer #(.BIT_NS(50)) peer (.line_in(ser_tx_pin[0]),
      .line_out(peer_rx), .cts_n(peer_cts));
   initial forever #2.5 core_clk = ~core_clk;
   // one command strobe for one cycle
   task automatic st(input logic s, p, r, d, input logic [7:0] x);
      cmd = '{s, p, r, d, x};
      @(posedge core_clk);
      #1;
   endtask
   // write n payload bytes, most significant first
   task automatic wr(input logic [7:0] a, input logic [79:0] x, int n);
      st(1, 0, 0, 0, 0);
      st(0, 0, 0, 1, a);
      for (int i = n - 1; i >= 0; i--) st(0, 0, 0, 1, x[i*8+:8]);
      st(0, 1, 0, 0, 0);
      st(0, 0, 0, 0, 0);
      if (a == CMD_PSEL && x[1:0] != 2'h3) sel = x[1:0];
      if (a == CMD_LINE && n >= 10) mdl[sel] = x;
   endtask
   // push one byte into port 0's transmit queue
   task automatic tx_push(input logic [7:0] d);
      tx_data[0] = d;
      tx_valid[0] = 1'b1;
      @(posedge core_clk);
      #1 tx_valid[0] = 1'b0;
   endtask
   // read n reply bytes into the low end of x
   task automatic rd(input logic [7:0] a, int n, output logic [79:0] x);
      x = '0;
      st(1, 0, 1, 0, 0);
      st(0, 0, 0, 1, a);
      st(0, 1, 0, 0, 0);
      st(0, 0, 0, 0, 0);
      rsp_take = 1'b1;
      repeat (n) begin
         x = {x[71:0], rsp_byte};
         @(posedge core_clk);
         #1;
      end
      rsp_take = 1'b0;
      `CHK("reply end", 1'b0, rsp_valid)
   endtask
   task automatic end_of_test;
      $display("comparisons %0d num_errors %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      #100000;
      num_errors++;
      end_of_test;
   end
   initial begin
      void'($urandom(32'had81));
      repeat (5) @(posedge core_clk);
      #1 arst_n = 1'b1;
      rd(CMD_LINE, 10, v);
      `CHK("line reset", 80'h0, v)
      wr(CMD_PSEL, 80'h1, 1);
      wr(CMD_LINE, 80'h1_0A01_8100_0000_0000, 10);
      wr(CMD_PSEL, 80'h0, 1);
      wr(CMD_LINE, 80'h1_0A01_8000_0000_0000, 10);
      wr(CMD_LINE, 80'h0, 3);
      rd(CMD_LINE, 10, v);
      `CHK("line", mdl[0], v)
      rd(CMD_PSEL, 2, v);
      `CHK("port", 16'h0003, v[15:0])
      b = 8'($urandom);
      tx_push(b);
      repeat (300) if (peer.got.size() == 0) #5;
      `CHK("tx count", 1, peer.got.size())
      if (peer.got.size() > 0) `CHK("tx byte", b, peer.got[0])
      peer.hold(1'b1);
      wr(CMD_LINE, 80'h1_0A01_8000_0100_0000, 10);
      b = 8'($urandom);
      tx_push(b);
      repeat (40) @(posedge core_clk);
      `CHK("cts wait", 1, peer.got.size())
      peer.hold(1'b0);
      repeat (300) if (peer.got.size() < 2) #5;
      `CHK("cts go", b, peer.got[1])
      wr(CMD_SRC, 80'h0001, 2);
      rd(CMD_SRC, 1, v);
      `CHK("source", 8'h01, v[7:0])
      b = 8'($urandom);
      peer.send(b);
      repeat (100) if (rx_valid[1:0] !== 2'b11) #5;
      @(posedge core_clk);
      #1;
      `CHK("rx byte", b, rx_data[0])
      `CHK("rx routed", b, rx_data[1])
      `CHK("rx level", 2'b11, rx_level_flag[1:0])
      `CHK("tx level", 3'b111, tx_level_flag)
      `CHK("rts", 3'b000, request_to_send_n)
      rx_ready = 3'b011;
      @(posedge core_clk);
      #1 rx_ready = 3'b000;
      `CHK("rx empty", 3'b000, rx_valid)
      wr(CMD_UPD, 80'h1, 1);
      `CHK("link", 1'b1, update_link_on)
      wr(CMD_PSEL, 80'h1, 1);
      rd(CMD_LINE, 10, v);
      `CHK("line 1", mdl[1], v)
      end_of_test;
   end
endmodule // tb_spcfg_top
